//--- uarb_arbiter.sv
// Local DMA request arbiter: lockout, vector select, bus arbitration, fairness, TC status.
// Assumes a synchronous I/O strobe port; async bus and UART inputs are synchronised here.
//
// Summary of operation
// - Lockout idles until a gated request is active, then takes one.
// - Priority is receiver one, receiver two, transmitter one, transmitter two.
// - A request state asserts the local request low and drives the select code.
// - Hold request state until that request drops, ignoring others, then idle.
// - Stay idle until the local request has been inactive 100 ns.
// - Select code picks one of four vectors; transmitter one is fixed at 0111.
// - Drive the vector only with arbitration enable; flag bus won on match.
// - Bus machine leaves idle on local request and asserts preempt.
// - On arbitration cycle start, assert arbitration enable, keep preempt.
// - Lost cycle: drop enable, keep preempt, re-arbitrate on next cycle.
// - On winning, pass one state dropping preempt, then go to burst.
// - Burst state asserts burst; the DMA controller does the transfer.
// - Local request inactive: final state drops burst, then idle.
// - Fairness works only with bit 7 of option byte 102 set.
// - Each fairness machine resets to idle and moves to transfer on its request.
// - Request ends with fairness on and others pending: wait, degate asserted.
// - Others all gone: pass a degated intermediate state, release on idle.
// - A request passes only when enabled and not degated.
// - Terminal count with read or write and chip select names a channel.
// - A channel's terminal count clears its enable bit.
// - Any channel terminal count sets the status latch driving interrupt three.
// - Reading 2F7 returns the latch on bit 0 and clears it.
// - The enable register is four write-only bits; one enables a request.
// - Enable bits 0..3 gate tx2, tx1, rx2, rx1; upper bits ignored.
`timescale 1ns/10ps
`default_nettype none
`include "uarb_map.svh"
module uarb_arbiter (
  input  wire logic        ref_clk,             // 20 MHz clock.
  input  wire logic        reset_n,             // Asynchronous reset, active low.
  input  wire logic        clk_en,              // Freezes all state while low.
  input  wire logic        receive_one_strobe,  // Receiver one DMA strobe, async.
  input  wire logic        receive_two_strobe,  // Receiver two DMA strobe, async.
  input  wire logic        transmit_one_strobe, // Transmitter one DMA strobe, async.
  input  wire logic        transmit_two_strobe, // Transmitter two DMA strobe, async.
  input  wire logic [15:0] io_addr,             // I/O address, synchronous.
  input  wire logic        io_rd,               // I/O read strobe, one cycle.
  input  wire logic        io_wr,               // I/O write strobe, one cycle.
  input  wire logic [7:0]  io_wdata,            // I/O write data.
  output logic      [7:0]  io_rdata,            // I/O read data, registered.
  input  wire logic        uart_select_one,     // UART one chip select.
  input  wire logic        uart_select_two,     // UART two chip select.
  input  wire logic        term_count,          // Terminal count from bus, async.
  input  wire logic [7:0]  option_byte_102,     // Configuration byte holding fairness.
  input  wire logic [3:0]  vector_rx1,          // Arbitration vector for receiver one.
  input  wire logic [3:0]  vector_rx2,          // Arbitration vector for receiver two.
  input  wire logic [3:0]  vector_tx2,          // Arbitration vector for transmitter two.
  input  wire logic        arb_cycle,           // Arbitration cycle in progress, async.
  input  wire logic [3:0]  arb_bus_in,          // Arbitration bus level, async.
  output logic      [3:0]  arb_bus_out,         // Arbitration bus drive value.
  output logic      [3:0]  arb_bus_oe,          // Arbitration bus drive enables.
  output logic             preempt_n,           // Preempt, active low.
  output logic             burst_n,             // Burst, active low.
  output logic             local_dma_request_n, // Local request, active low.
  output logic             select_code_msb,     // Select code bit 1.
  output logic             select_code_lsb,     // Select code bit 0.
  output logic             transfer_done_irq    // Interrupt three.
);
  localparam int GAP_CYC = `UARB_REQ_GAP_CYC;

  // Two-stage synchronisers for everything not on ref_clk.
  logic [9:0] sy1_r;
  logic [9:0] sy2_r;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sy1_r <= 10'h000;
      sy2_r <= 10'h000;
    end else if (clk_en) begin
      sy1_r <= {arb_bus_in, arb_cycle, term_count, receive_one_strobe,
                receive_two_strobe, transmit_one_strobe, transmit_two_strobe};
      sy2_r <= sy1_r;
    end
  end
  logic [3:0] strobe_s;
  logic       tc_s;
  logic       arb_s;
  logic [3:0] arb_bus_s;
  assign strobe_s  = sy2_r[3:0];
  assign tc_s      = sy2_r[4];
  assign arb_s     = sy2_r[5];
  assign arb_bus_s = sy2_r[9:6];

  // Enable register, status latch and terminal count decode.
  logic [3:0] enable_r;
  logic [3:0] enable_nxt;
  logic       status_r;
  logic       status_nxt;
  logic       tc_d_r;
  logic [7:0] rdata_nxt;
  logic [3:0] tc_ch;
  logic       hit;
  // Last access kind is remembered so a late terminal count still decodes.
  logic       io_rd_seen;
  logic       io_wr_seen;
  logic       sel_one_seen;
  logic       sel_two_seen;
  always_comb begin
    hit = (io_addr == `UARB_STATUS_ADDR);
    tc_ch = 4'h0;
    if (tc_s && !tc_d_r) begin
      tc_ch[`UARB_EN_RX1_BIT] = io_rd_seen & sel_one_seen;
      tc_ch[`UARB_EN_RX2_BIT] = io_rd_seen & sel_two_seen;
      tc_ch[`UARB_EN_TX1_BIT] = io_wr_seen & sel_one_seen;
      tc_ch[`UARB_EN_TX2_BIT] = io_wr_seen & sel_two_seen;
    end
    enable_nxt = enable_r;
    if (io_wr && hit) enable_nxt = io_wdata[3:0];
    enable_nxt = enable_nxt & ~tc_ch;
    status_nxt = status_r;
    rdata_nxt  = 8'h00;
    if (io_rd && hit) begin
      rdata_nxt[`UARB_STATUS_BIT] = status_r;
      status_nxt = 1'b0;
    end
    if (|tc_ch) status_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rd_seen   <= 1'b0;
      io_wr_seen   <= 1'b0;
      sel_one_seen <= 1'b0;
      sel_two_seen <= 1'b0;
    end else if (clk_en && (io_rd || io_wr)) begin
      io_rd_seen   <= io_rd;
      io_wr_seen   <= io_wr;
      sel_one_seen <= uart_select_one;
      sel_two_seen <= uart_select_two;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_r <= `UARB_ENABLE_RESET;
      status_r <= 1'b0;
      tc_d_r   <= 1'b0;
      io_rdata <= 8'h00;
    end else if (clk_en) begin
      enable_r <= enable_nxt;
      status_r <= status_nxt;
      tc_d_r   <= tc_s;
      io_rdata <= rdata_nxt;
    end
  end

  // Gated requests, bit 3 rx1 .. bit 0 tx2.
  uarb_fair_if fi ();
  logic [3:0] req;
  assign req        = strobe_s & enable_r & ~fi.degate;
  assign fi.req     = req;
  assign fi.fair_en = option_byte_102[`UARB_FAIR_ENABLE_BIT];
  assign fi.preempt = ~preempt_n;
  uarb_fairness u_fair (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .fi      (fi)
  );

  // Lockout machine.
  uarb_pkg::uarb_lock_t lk_r;
  uarb_pkg::uarb_lock_t lk_nxt;
  logic [`UARB_GAP_W-1:0] gap_r;
  logic [`UARB_GAP_W-1:0] gap_nxt;
  logic                   local_dma_request_nxt;
  logic [1:0]             sel_nxt;
  logic [1:0]             sel_r;
  always_comb begin
    lk_nxt  = lk_r;
    gap_nxt = gap_r;
    case (lk_r)
      uarb_pkg::LK_IDLE: begin
        if (req[3]) lk_nxt = uarb_pkg::LK_RX1;
        else if (req[2]) lk_nxt = uarb_pkg::LK_RX2;
        else if (req[1]) lk_nxt = uarb_pkg::LK_TX1;
        else if (req[0]) lk_nxt = uarb_pkg::LK_TX2;
      end
      uarb_pkg::LK_RX1: if (!req[3]) lk_nxt = uarb_pkg::LK_GAP;
      uarb_pkg::LK_RX2: if (!req[2]) lk_nxt = uarb_pkg::LK_GAP;
      uarb_pkg::LK_TX1: if (!req[1]) lk_nxt = uarb_pkg::LK_GAP;
      uarb_pkg::LK_TX2: if (!req[0]) lk_nxt = uarb_pkg::LK_GAP;
      default: begin
        gap_nxt = gap_r + `UARB_GAP_W'(1);
        if (gap_r >= `UARB_GAP_W'(GAP_CYC - 1)) begin
          lk_nxt  = uarb_pkg::LK_IDLE;
          gap_nxt = '0;
        end
      end
    endcase
    local_dma_request_nxt = !(lk_nxt inside {uarb_pkg::LK_IDLE, uarb_pkg::LK_GAP});
    case (lk_nxt)
      uarb_pkg::LK_RX2: sel_nxt = 2'h1;
      uarb_pkg::LK_TX1: sel_nxt = 2'h2;
      uarb_pkg::LK_TX2: sel_nxt = 2'h3;
      uarb_pkg::LK_RX1: sel_nxt = 2'h0;
      default:          sel_nxt = sel_r;
    endcase
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_r                <= uarb_pkg::LK_IDLE;
      gap_r               <= '0;
      sel_r               <= 2'h0;
      local_dma_request_n <= 1'b1;
    end else if (clk_en) begin
      lk_r                <= lk_nxt;
      gap_r               <= gap_nxt;
      sel_r               <= sel_nxt;
      local_dma_request_n <= ~local_dma_request_nxt;
    end
  end
  assign select_code_msb = sel_r[1];
  assign select_code_lsb = sel_r[0];

  // Vector selection and compare.
  logic [3:0] vector;
  logic       bus_won;
  always_comb begin
    case (sel_r)
      2'h0:    vector = vector_rx1;
      2'h1:    vector = vector_rx2;
      2'h2:    vector = `UARB_TX1_VECTOR;
      default: vector = vector_tx2;
    endcase
    bus_won = (arb_bus_s == vector);
  end

  // Bus arbitration machine.
  uarb_pkg::uarb_bus_t ba_r;
  uarb_pkg::uarb_bus_t ba_nxt;
  logic                arb_en;
  always_comb begin
    ba_nxt = ba_r;
    case (ba_r)
      uarb_pkg::BA_IDLE: if (!local_dma_request_n) ba_nxt = uarb_pkg::BA_REQ;
      uarb_pkg::BA_REQ:  if (arb_s) ba_nxt = uarb_pkg::BA_ARB;
      uarb_pkg::BA_ARB: begin
        if (!arb_s) ba_nxt = bus_won ? uarb_pkg::BA_WON : uarb_pkg::BA_LOSE;
      end
      uarb_pkg::BA_LOSE:  if (arb_s) ba_nxt = uarb_pkg::BA_ARB;
      uarb_pkg::BA_WON:   ba_nxt = uarb_pkg::BA_BURST;
      uarb_pkg::BA_BURST: if (local_dma_request_n) ba_nxt = uarb_pkg::BA_END;
      default:            ba_nxt = uarb_pkg::BA_IDLE;
    endcase
    arb_en = (ba_nxt == uarb_pkg::BA_ARB);
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ba_r              <= uarb_pkg::BA_IDLE;
      preempt_n         <= 1'b1;
      burst_n           <= 1'b1;
      arb_bus_oe        <= 4'h0;
      arb_bus_out       <= 4'h0;
      transfer_done_irq <= 1'b0;
    end else if (clk_en) begin
      ba_r      <= ba_nxt;
      preempt_n <= !(ba_nxt inside {uarb_pkg::BA_REQ, uarb_pkg::BA_ARB,
                                    uarb_pkg::BA_LOSE});
      burst_n     <= (ba_nxt != uarb_pkg::BA_BURST);
      arb_bus_oe  <= {4{arb_en}};
      arb_bus_out <= arb_en ? vector : 4'h0;
      transfer_done_irq <= status_nxt;
    end
  end
endmodule : uarb_arbiter
`default_nettype wire

//--- uarb_map.svh
// Register offsets, field positions, reset values and timing counts of the arbiter.
// Assumes inclusion by bare name; definitions only.
`ifndef UARB_MAP_SVH
`define UARB_MAP_SVH
`define UARB_IO_ADDR_W        16
`define UARB_STATUS_ADDR      16'h02F7
`define UARB_STATUS_BIT       0
`define UARB_ENABLE_RESET     4'h0
`define UARB_EN_TX2_BIT       0
`define UARB_EN_TX1_BIT       1
`define UARB_EN_RX2_BIT       2
`define UARB_EN_RX1_BIT       3
`define UARB_FAIR_ENABLE_BIT  7
`define UARB_TX1_VECTOR       4'h7
`define UARB_CLK_PERIOD_NS    50
`define UARB_REQ_GAP_NS       100
`define UARB_REQ_GAP_CYC      ((`UARB_REQ_GAP_NS + `UARB_CLK_PERIOD_NS - 1) / `UARB_CLK_PERIOD_NS)
`define UARB_GAP_W            3
`endif

//--- uarb_pkg.sv
// Types shared by the arbiter modules.
// Assumes nothing of its surroundings.
package uarb_pkg;
  typedef enum logic [5:0] {
    LK_IDLE = 6'h01,
    LK_RX1  = 6'h02,
    LK_RX2  = 6'h04,
    LK_TX1  = 6'h08,
    LK_TX2  = 6'h10,
    LK_GAP  = 6'h20
  } uarb_lock_t;
  typedef enum logic [6:0] {
    BA_IDLE  = 7'h01,
    BA_REQ   = 7'h02,
    BA_ARB   = 7'h04,
    BA_LOSE  = 7'h08,
    BA_WON   = 7'h10,
    BA_BURST = 7'h20,
    BA_END   = 7'h40
  } uarb_bus_t;
  typedef enum logic [1:0] {
    FR_WAIT = 2'b00,
    FR_TEMP = 2'b01,
    FR_XFR  = 2'b10,
    FR_IDLE = 2'b11
  } uarb_fair_t;
endpackage : uarb_pkg

//--- uarb_fair_if.sv
// Carries requests and degate outputs between the arbiter and its fairness bank.
// Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
interface uarb_fair_if;
  logic [3:0] req;
  logic       fair_en;
  logic       preempt;
  logic [3:0] degate;
  modport arb  (output req, output fair_en, output preempt, input degate);
  modport fair (input req, input fair_en, input preempt, output degate);
endinterface : uarb_fair_if
`default_nettype wire

//--- uarb_fairness.sv
// Four fairness machines, one per gated request, index 3 rx1 down to 0 tx2.
// Assumes inputs already synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module uarb_fairness (
  input  wire logic ref_clk,  // Clock.
  input  wire logic reset_n,  // Asynchronous reset.
  input  wire logic clk_en,   // Freezes state when low.
  uarb_fair_if.fair fi        // Requests and degates.
);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_fair
      uarb_pkg::uarb_fair_t st_r;
      uarb_pkg::uarb_fair_t st_nxt;
      logic                 others;
      always_comb begin
        others = (|(fi.req & ~(4'h1 << g))) | fi.preempt;
        st_nxt = st_r;
        case (st_r)
          uarb_pkg::FR_IDLE: if (fi.req[g]) st_nxt = uarb_pkg::FR_XFR;
          uarb_pkg::FR_XFR: begin
            if (!fi.req[g]) begin
              if (fi.fair_en && others) st_nxt = uarb_pkg::FR_WAIT;
              else st_nxt = uarb_pkg::FR_IDLE;
            end
          end
          uarb_pkg::FR_WAIT: if (!others) st_nxt = uarb_pkg::FR_TEMP;
          default: st_nxt = uarb_pkg::FR_IDLE;
        endcase
      end
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) st_r <= uarb_pkg::FR_IDLE;
        else if (clk_en) st_r <= st_nxt;
      end
      assign fi.degate[g] = ~st_r[1];
    end
  endgenerate
endmodule : uarb_fairness
`default_nettype wire

//--- uarb_arbiter_monitor.sv
// Concurrent checks on the arbiter's top-level ports.
// Assumes one clock domain; attached by the bind after the module.
`timescale 1ns/10ps
`default_nettype none
`include "uarb_map.svh"
module uarb_arbiter_monitor (
  input wire logic        ref_clk,             // Clock.
  input wire logic        reset_n,             // Reset.
  input wire logic [15:0] io_addr,             // Address.
  input wire logic        io_rd,               // Read.
  input wire logic [7:0]  io_rdata,            // Read data.
  input wire logic [3:0]  vector_rx1,          // Vector.
  input wire logic [3:0]  vector_rx2,          // Vector.
  input wire logic [3:0]  vector_tx2,          // Vector.
  input wire logic [3:0]  arb_bus_out,         // Bus value.
  input wire logic [3:0]  arb_bus_oe,          // Enables.
  input wire logic        preempt_n,           // Preempt.
  input wire logic        burst_n,             // Burst.
  input wire logic        local_dma_request_n, // Request.
  input wire logic        select_code_msb,     // Select.
  input wire logic        select_code_lsb,     // Select.
  input wire logic        transfer_done_irq    // Interrupt.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] exp_vec;
  always_comb begin
    case ({select_code_msb, select_code_lsb})
      2'h0: exp_vec = vector_rx1;
      2'h1: exp_vec = vector_rx2;
      2'h2: exp_vec = `UARB_TX1_VECTOR;
      default: exp_vec = vector_tx2;
    endcase
  end
  property p_gap; $rose(local_dma_request_n) |-> local_dma_request_n [*2]; endproperty
  a_gap: assert property (p_gap) else $error("request gap short");
  property p_go; $fell(local_dma_request_n) |-> ##[1:2] !preempt_n; endproperty
  a_go: assert property (p_go) else $error("no preempt");
  property p_oe; |arb_bus_oe |-> arb_bus_oe == 4'hF && !preempt_n && !local_dma_request_n; endproperty
  a_oe: assert property (p_oe) else $error("bad drive");
  property p_vec; |arb_bus_oe |-> arb_bus_out == exp_vec; endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_won; $fell(burst_n) |-> $past(preempt_n) && !$past(preempt_n, 2); endproperty
  a_won: assert property (p_won) else $error("no single won step");
  property p_bpre; !burst_n |-> preempt_n; endproperty
  a_bpre: assert property (p_bpre) else $error("preempt in burst");
  property p_breq; $fell(burst_n) |-> !local_dma_request_n; endproperty
  a_breq: assert property (p_breq) else $error("burst without request");
  property p_end; $rose(local_dma_request_n) && !burst_n |-> ##[1:3] burst_n; endproperty
  a_end: assert property (p_end) else $error("burst stuck");
  property p_sel; !local_dma_request_n && $past(!local_dma_request_n) |-> $stable({select_code_msb, select_code_lsb}); endproperty
  a_sel: assert property (p_sel) else $error("select moved");
  property p_oth; io_rd && io_addr != `UARB_STATUS_ADDR |=> io_rdata == 8'h00; endproperty
  a_oth: assert property (p_oth) else $error("unmapped read");
  property p_st; io_rd && io_addr == `UARB_STATUS_ADDR |=> io_rdata == {7'h00, $past(transfer_done_irq)}; endproperty
  a_st: assert property (p_st) else $error("status read");
  c_burst: cover property ($fell(burst_n));
  c_lose: cover property ($fell(arb_bus_oe[0]) && !preempt_n);
  c_irq: cover property ($rose(transfer_done_irq));
endmodule : uarb_arbiter_monitor
bind uarb_arbiter uarb_arbiter_monitor uarb_arbiter_monitor_inst (.ref_clk, .reset_n,
  .io_addr, .io_rd, .io_rdata, .vector_rx1, .vector_rx2, .vector_tx2, .arb_bus_out,
  .arb_bus_oe, .preempt_n, .burst_n, .local_dma_request_n, .select_code_msb,
  .select_code_lsb, .transfer_done_irq);
`default_nettype wire

//--- uarb_central_model.sv
// Behavioural central arbiter running arbitration cycles while preempt is low.
// Assumes a pulled-up arbitration bus on which the lower value wins.
`timescale 1ns/10ps
`default_nettype none
module uarb_central_model (
  input  wire logic       ref_clk,     // Clock.
  input  wire logic       reset_n,     // Reset.
  input  wire logic       preempt_n,   // Bus request.
  input  wire logic       burst_n,     // Burst.
  input  wire logic [3:0] arb_bus_out, // Adapter value.
  input  wire logic [3:0] arb_bus_oe,  // Adapter enables.
  input  wire logic       rival_on,    // A rival wins one cycle.
  output logic            arb_cycle,   // Arbitration cycle.
  output logic      [3:0] arb_bus_in,  // Resolved bus.
  output logic      [3:0] arb_count    // Cycles this grant.
);
  logic [3:0] tmr;
  logic       lost;
  logic       burst_q;
  logic       rival_q;
  // The rival's drive is latched as each cycle starts, so it holds while the adapter samples.
  assign arb_bus_in = ((arb_bus_out & arb_bus_oe) | ~arb_bus_oe) & (rival_q ? 4'h0 : 4'hF);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      arb_cycle <= 1'b0;
      tmr       <= 4'h0;
      lost      <= 1'b0;
      burst_q   <= 1'b1;
      rival_q   <= 1'b0;
      arb_count <= 4'h0;
    end else begin
      burst_q <= burst_n;
      tmr     <= (preempt_n && !arb_cycle) ? 4'h0 : tmr + 4'h1;
      if (!arb_cycle && tmr == 4'h8) begin
        arb_cycle <= 1'b1;
        rival_q   <= rival_on && !lost;
        tmr       <= 4'h0;
      end
      if (arb_cycle && tmr == 4'h6) begin
        arb_cycle <= 1'b0;
        tmr       <= 4'h0;
        arb_count <= arb_count + 4'h1;
        lost      <= rival_on;
      end
      if (burst_n && !burst_q) begin
        arb_count <= 4'h0;
        lost      <= 1'b0;
      end
    end
  end
endmodule : uarb_central_model
`default_nettype wire

//--- uarb_arbiter_test.sv
// Self-checking bench for the arbiter beside a central arbiter model.
// Assumes the design, its header and the model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "uarb_map.svh"
module uarb_arbiter_test;
  logic        ref_clk, reset_n, io_rd, io_wr, term_count, rival_on, arb_cycle;
  logic        uart_select_one, uart_select_two, preempt_n, burst_n, local_dma_request_n;
  logic        select_code_msb, select_code_lsb, transfer_done_irq;
  logic [3:0]  strb, vector_rx1, vector_rx2, vector_tx2, arb_bus_in, arb_bus_out, arb_bus_oe;
  logic [3:0]  arb_count, m;
  logic [7:0]  io_wdata, io_rdata, option_byte_102;
  logic [15:0] io_addr;
  logic [31:0] seed;
  int          bad_count, tests_run;
  wire logic [1:0] mon = {burst_n, local_dma_request_n};
  uarb_arbiter uarb_arbiter_inst (.ref_clk, .reset_n, .clk_en(1'b1),
    .receive_one_strobe(strb[0]), .receive_two_strobe(strb[1]), .transmit_one_strobe(strb[2]),
    .transmit_two_strobe(strb[3]), .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
    .uart_select_one, .uart_select_two, .term_count, .option_byte_102, .vector_rx1,
    .vector_rx2, .vector_tx2, .arb_cycle, .arb_bus_in, .arb_bus_out, .arb_bus_oe, .preempt_n,
    .burst_n, .local_dma_request_n, .select_code_msb, .select_code_lsb, .transfer_done_irq);
  uarb_central_model uarb_central_model_inst (.ref_clk, .reset_n, .preempt_n, .burst_n,
    .arb_bus_out, .arb_bus_oe, .rival_on, .arb_cycle, .arb_bus_in, .arb_count);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [1:0] top_sel(input logic [3:0] r);
    top_sel = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (r[i]) top_sel = i[1:0];
    end
  endfunction : top_sel
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tk
  task automatic wt(input int i, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (mon[i] !== v && n < 300);
    chk({7'h0, mon[i]}, {7'h0, v});
  endtask : wt
  task automatic io(input logic rd, input logic wr, input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] cs);
    @(posedge ref_clk);
    {io_rd, io_wr, io_addr, io_wdata, uart_select_two, uart_select_one} <= {rd, wr, a, d, cs};
    @(posedge ref_clk);
    {io_rd, io_wr} <= 2'b00;
    #1;
  endtask : io
  task automatic serve(input logic [1:0] s, input logic [3:0] narb, input logic glitch);
    wt(0, 1'b0);
    chk({6'h0, select_code_msb, select_code_lsb}, {6'h0, s});
    wt(1, 1'b0);
    chk({4'h0, arb_count}, {4'h0, narb});
    @(posedge ref_clk);
    strb[s] <= 1'b0;
    if (glitch) begin
      @(posedge ref_clk);
      strb[s] <= 1'b1;
    end
    wt(0, 1'b1);
    wt(1, 1'b1);
  endtask : serve
  task automatic conclude();
    $display("counts: run=%0d bad=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end
  initial begin
    {strb, io_rd, io_wr, uart_select_one, uart_select_two, term_count, rival_on} = '0;
    {io_addr, io_wdata, option_byte_102} = '0;
    seed = lfsr(32'h8492CC45);
    {vector_rx1, vector_rx2, vector_tx2} = seed[11:0] | 12'h111;
    reset_n = 1'b0;
    tk(8);
    reset_n <= 1'b1;
    tk(1);
    #1;
    chk({3'h0, preempt_n, burst_n, local_dma_request_n, transfer_done_irq, |arb_bus_oe}, 8'h1C);
    io(1'b1, 1'b0, `UARB_STATUS_ADDR, 8'h00, 2'h0);
    chk(io_rdata, 8'h00);
    $display("reset test done");
    io(1'b0, 1'b1, `UARB_STATUS_ADDR, 8'hAF, 2'h0);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      io(1'b1, 1'b0, {seed[15:1], 1'b0}, 8'h00, 2'h0);
      chk(io_rdata, 8'h00);
      m = (k == 0 || seed[19:16] == 4'h0) ? 4'hF : seed[19:16];
      strb <= m;
      while (m != 4'h0) begin
        serve(top_sel(m), 4'h1, 1'b0);
        m[top_sel(m)] = 1'b0;
      end
    end
    $display("priority test done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      io(1'b0, 1'b1, `UARB_STATUS_ADDR, {seed[7:4], 4'h1 << i}, 2'h0);
      strb <= 4'hF;
      serve(2'h3 - i[1:0], 4'h1, 1'b0);
      tk(8);
      #1;
      chk({7'h0, local_dma_request_n}, 8'h01);
      strb <= 4'h0;
    end
    $display("enable test done");
    io(1'b0, 1'b1, `UARB_STATUS_ADDR, 8'h0F, 2'h0);
    rival_on <= 1'b1;
    strb <= 4'h4;
    serve(2'h2, 4'h2, 1'b0);
    rival_on <= 1'b0;
    $display("lose test done");
    for (int f = 0; f < 2; f++) begin
      seed = lfsr(seed);
      @(posedge ref_clk);
      option_byte_102 <= {f[0], seed[6:0]};
      strb <= 4'h9;
      serve(2'h0, 4'h1, 1'b1);
      serve(f[0] ? 2'h3 : 2'h0, 4'h1, 1'b0);
      serve(f[0] ? 2'h0 : 2'h3, 4'h1, 1'b0);
    end
    $display("fairness test done");
    for (int c = 0; c < 4; c++) begin
      io(1'b0, 1'b1, `UARB_STATUS_ADDR, 8'h0F, 2'h0);
      io(c < 2, c >= 2, 16'h02F8, 8'h00, c[0] ? 2'h2 : 2'h1);
      term_count <= 1'b1;
      tk(3);
      term_count <= 1'b0;
      tk(6);
      #1;
      chk({7'h0, transfer_done_irq}, 8'h01);
      io(1'b1, 1'b0, `UARB_STATUS_ADDR, 8'h00, 2'h0);
      chk(io_rdata, 8'h01);
      tk(2);
      #1;
      chk({7'h0, transfer_done_irq}, 8'h00);
      io(1'b1, 1'b0, `UARB_STATUS_ADDR, 8'h00, 2'h0);
      chk(io_rdata, 8'h00);
      strb[c] <= 1'b1;
      tk(8);
      #1;
      chk({7'h0, local_dma_request_n}, 8'h01);
      strb <= 4'h1 << (c ^ 1);
      serve(c[1:0] ^ 2'h1, 4'h1, 1'b0);
    end
    $display("terminal count test done");
    conclude();
  end
endmodule : uarb_arbiter_test
`default_nettype wire
